// ### rtl/wdt24_pkg.sv
// package: register map, field positions, reset values and timing constants of the watchdog
package wdt24_pkg;
    // register indices; the byte address is index * 4
    localparam logic [11:0] WDT24_IDX_RESET_STATUS_REGISTER = 12'hff0;
    localparam logic [11:0] WDT24_IDX_UPPER   = 12'hff1;
    localparam logic [11:0] WDT24_IDX_MIDDLE  = 12'hff2;
    localparam logic [11:0] WDT24_IDX_LOW     = 12'hff3;
    localparam logic [11:0] WDT24_IDX_CTRL    = 12'hff4;
    localparam logic [11:0] WDT24_IDX_IRQST   = 12'hff5;
    localparam logic [11:0] WDT24_IDX_IRQMSK  = 12'hff6;
    localparam logic [11:0] WDT24_IDX_STATUS  = 12'hff7;
    localparam int          WDT24_AW          = 14;

    // reload byte reset values
    localparam logic [7:0]  WDT24_RST_UPPER   = 8'h00;
    localparam logic [7:0]  WDT24_RST_MIDDLE  = 8'h04;
    localparam logic [7:0]  WDT24_RST_LOW     = 8'h00;

    // counter constants
    localparam logic [23:0] WDT24_ZERO        = 24'h00_0000;
    localparam logic [23:0] WDT24_MAXCNT      = 24'h0F_FFFF;

    // reset status register fields
    localparam int          WDT24_RS_WDT      = 5;
    localparam int          WDT24_RS_STOP     = 4;
    // control register fields
    localparam int          WDT24_CT_EN       = 0;
    // interrupt status / mask fields
    localparam int          WDT24_IRQ_TMO     = 0;
    localparam int          WDT24_IRQ_RLD     = 1;
    localparam int          WDT24_IRQ_SMR     = 2;
    localparam int          WDT24_NIRQ        = 3;

    // watchdog tick period in ns, and derived cycle count at 100 MHz
    localparam int          WDT24_CLK_NS      = 10;
    localparam int          WDT24_TICK_NS     = 10;
    localparam int          WDT24_TICK_CYC    = (WDT24_TICK_NS / WDT24_CLK_NS < 1) ? 1 :
                                                WDT24_TICK_NS / WDT24_CLK_NS;
endpackage

// ### rtl/wdt24_sync.sv
// two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module wdt24_sync
    import wdt24_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    // first stage is read only by the second
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // wdt24_sync

// ### rtl/wdt24_counter.sv
// 24-bit watchdog down-counter with load, jump-to-max and tick gating
`timescale 1ns/1ps
module wdt24_counter
    import wdt24_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        enable,
    input  wire logic        load,
    input  wire logic [23:0] load_val,
    input  wire logic        jump_max,
    output logic [23:0]      count_q,
    output logic             zero_hit
);
    logic [15:0] tick_cnt_q;
    logic        tick;

    assign tick = (tick_cnt_q == 16'(WDT24_TICK_CYC - 1));

    always_ff @(posedge sys_clk) begin
        if (!nrst || !enable || tick) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // load wins over jump and decrement; a refresh in the zero cycle cancels the time-out
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            count_q <= WDT24_ZERO;
        end else if (load) begin
            count_q <= load_val;
        end else if (jump_max) begin
            count_q <= WDT24_MAXCNT;
        end else if (enable && tick && count_q != WDT24_ZERO) begin
            count_q <= count_q - 24'h00_0001;
        end
    end

    // high while enabled, count_q is zero and no load; only load or jump_max moves the counter off zero
    assign zero_hit = enable && !load && (count_q == WDT24_ZERO);
endmodule // wdt24_counter

// ### rtl/wdt24_top.sv
// watchdog top: APB register slave, time-out response and interrupt logic
`timescale 1ns/1ps
module wdt24_top
    import wdt24_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        refresh_instr,
    input  wire logic        timeout_response_select,
    input  wire logic        stop_mode,
    output logic             wdt_irq_req,
    output logic             sys_reset_req,
    output logic             stop_recovery_req,
    output logic             irq
);
    logic              stop_sync;
    logic [7:0]        rld_upper_q;
    logic [7:0]        rld_middle_q;
    logic [7:0]        rld_low_q;
    logic [23:0]       reload_val;
    logic              enable_q;
    logic              loaded_q;
    logic              load;
    logic              zero_hit;
    logic [23:0]       count;
    logic              resp_irq_mode_q;
    logic              flag_wdt_q;
    logic              flag_stop_q;
    logic [WDT24_NIRQ-1:0] irq_st_q;
    logic [WDT24_NIRQ-1:0] irq_msk_q;
    logic [WDT24_NIRQ-1:0] irq_ev;
    logic              setup;
    logic              wr_en;
    logic              rd_en;
    logic [11:0]       idx;
    logic              idx_ok;
    logic              rd_reset_status_register;
    logic              tmo_irq;
    logic              tmo_rst;
    logic              strap_taken_q;
    logic [31:0]       rdata_d;

    // stop_mode is a pin-level input from the power controller
    wdt24_sync u_stop_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .din     (stop_mode),
        .dout    (stop_sync)
    );

    // apb decode: zero-wait-state slave, answers in the access cycle
    assign setup  = psel && !penable;
    assign idx    = paddr[13:2];
    assign idx_ok = (paddr[1:0] == 2'b00) && (paddr[31:WDT24_AW] == '0) &&
                    (idx >= WDT24_IDX_RESET_STATUS_REGISTER) && (idx <= WDT24_IDX_STATUS);
    assign wr_en  = psel && penable && pready && pwrite && idx_ok;
    assign rd_en  = psel && penable && pready && !pwrite && idx_ok;
    assign rd_reset_status_register = rd_en && (idx == WDT24_IDX_RESET_STATUS_REGISTER);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !((paddr[1:0] == 2'b00) && (paddr[31:WDT24_AW] == '0) &&
                       (paddr[13:2] >= WDT24_IDX_RESET_STATUS_REGISTER) && (paddr[13:2] <= WDT24_IDX_STATUS));
        end
    end

    // reload bytes
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rld_upper_q  <= WDT24_RST_UPPER;
            rld_middle_q <= WDT24_RST_MIDDLE;
            rld_low_q    <= WDT24_RST_LOW;
        end else if (wr_en) begin
            if (idx == WDT24_IDX_UPPER) begin
                rld_upper_q <= pwdata[7:0];
            end
            if (idx == WDT24_IDX_MIDDLE) begin
                rld_middle_q <= pwdata[7:0];
            end
            if (idx == WDT24_IDX_LOW) begin
                rld_low_q <= pwdata[7:0];
            end
        end
    end

    assign reload_val = {rld_upper_q, rld_middle_q, rld_low_q};

    // enable and first-load tracking
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            enable_q <= 1'b0;
            loaded_q <= 1'b0;
        end else begin
            if (wr_en && idx == WDT24_IDX_CTRL) begin
                enable_q <= pwdata[WDT24_CT_EN];
            end
            if (load) begin
                loaded_q <= 1'b1;
            end
        end
    end

    // refresh reloads only while running; first enable loads once
    assign load = enable_q && (!loaded_q || refresh_instr);

    // response mode strap, caught after reset release
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            strap_taken_q   <= 1'b0;
            resp_irq_mode_q <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_taken_q   <= 1'b1;
            resp_irq_mode_q <= timeout_response_select;
        end
    end

    wdt24_counter u_counter (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .enable   (enable_q && loaded_q),
        .load     (load),
        .load_val (reload_val),
        .jump_max (tmo_irq),
        .count_q  (count),
        .zero_hit (zero_hit)
    );

    // zero_hit lasts one cycle in irq mode since the counter jumps to max; in reset mode it stays high until a load, a CTRL write clearing the enable bit, or nrst
    assign tmo_irq = zero_hit && resp_irq_mode_q && strap_taken_q;
    assign tmo_rst = zero_hit && !resp_irq_mode_q && strap_taken_q;

    // response outputs: wdt_irq_req pulses one cycle; sys_reset_req stays high while zero_hit holds
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wdt_irq_req       <= 1'b0;
            sys_reset_req     <= 1'b0;
            stop_recovery_req <= 1'b0;
        end else begin
            wdt_irq_req       <= tmo_irq;
            sys_reset_req     <= tmo_rst;
            stop_recovery_req <= tmo_irq && stop_sync;
        end
    end

    // status flags: set wins over read-clear
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            flag_wdt_q  <= 1'b0;
            flag_stop_q <= 1'b0;
        end else begin
            if (zero_hit && strap_taken_q) begin
                flag_wdt_q <= 1'b1;
            end else if (rd_reset_status_register) begin
                flag_wdt_q <= 1'b0;
            end
            if (zero_hit && strap_taken_q && stop_sync) begin
                flag_stop_q <= 1'b1;
            end else if (rd_reset_status_register) begin
                flag_stop_q <= 1'b0;
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    assign irq_ev[WDT24_IRQ_TMO] = tmo_irq;
    assign irq_ev[WDT24_IRQ_RLD] = load && loaded_q;
    assign irq_ev[WDT24_IRQ_SMR] = tmo_irq && stop_sync;

    genvar gi;
    generate
        for (gi = 0; gi < WDT24_NIRQ; gi++) begin : g_irq
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    irq_st_q[gi] <= 1'b0;
                end else if (irq_ev[gi]) begin
                    irq_st_q[gi] <= 1'b1;
                end else if (wr_en && idx == WDT24_IDX_IRQST && pwdata[gi]) begin
                    irq_st_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            irq_msk_q <= '0;
        end else if (wr_en && idx == WDT24_IDX_IRQMSK) begin
            irq_msk_q <= pwdata[WDT24_NIRQ-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_st_q & irq_msk_q);
        end
    end

    // read mux; reload addresses show the live count
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (idx)
            WDT24_IDX_RESET_STATUS_REGISTER: begin
                rdata_d[WDT24_RS_WDT]  = flag_wdt_q;
                rdata_d[WDT24_RS_STOP] = flag_stop_q;
            end
            WDT24_IDX_UPPER:  rdata_d[7:0] = count[23:16];
            WDT24_IDX_MIDDLE: rdata_d[7:0] = count[15:8];
            WDT24_IDX_LOW:    rdata_d[7:0] = count[7:0];
            WDT24_IDX_CTRL:   rdata_d[WDT24_CT_EN] = enable_q;
            WDT24_IDX_IRQST:  rdata_d[WDT24_NIRQ-1:0] = irq_st_q;
            WDT24_IDX_IRQMSK: rdata_d[WDT24_NIRQ-1:0] = irq_msk_q;
            WDT24_IDX_STATUS: begin
                rdata_d[0] = resp_irq_mode_q;
                rdata_d[1] = loaded_q;
                rdata_d[2] = stop_sync;
            end
            default:          rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= rdata_d;
        end
    end
endmodule // wdt24_top

// ### tb/wdt24_chk.sv
// checker: port-level properties of the watchdog top
`timescale 1ns/1ps
module wdt24_chk (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timeout_response_select,
    input wire logic        stop_mode,
    input wire logic        wdt_irq_req,
    input wire logic        sys_reset_req,
    input wire logic        stop_recovery_req,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    property p_one_resp;
        disable iff (!nrst) !(wdt_irq_req && sys_reset_req);
    endproperty
    a_one_resp: assert property (p_one_resp) else $error("two responses at once");
    // jump to max keeps the next time-out far away
    property p_irq_once;
        disable iff (!nrst) wdt_irq_req |=> !wdt_irq_req [*8];
    endproperty
    a_irq_once: assert property (p_irq_once) else $error("irq request repeated");
    property p_irq_mode;
        disable iff (!nrst) wdt_irq_req |-> timeout_response_select;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq in reset mode");
    property p_rst_mode;
        disable iff (!nrst) sys_reset_req |-> !timeout_response_select;
    endproperty
    a_rst_mode: assert property (p_rst_mode) else $error("reset in irq mode");
    property p_rec_irq;
        disable iff (!nrst) stop_recovery_req |-> wdt_irq_req;
    endproperty
    a_rec_irq: assert property (p_rec_irq) else $error("recovery without irq");
    property p_rec_stop;
        disable iff (!nrst) wdt_irq_req && stop_mode && $past(stop_mode, 4) |-> stop_recovery_req;
    endproperty
    a_rec_stop: assert property (p_rec_stop) else $error("no recovery in stop");
    property p_ready;
        disable iff (!nrst) psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_err_zero;
        disable iff (!nrst) pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    property p_rd_byte;
        disable iff (!nrst) pready && !pwrite |-> prdata[31:8] == 24'h00_0000;
    endproperty
    a_rd_byte: assert property (p_rd_byte) else $error("upper read bits set");
    property p_rst_out;
        !nrst |=> !wdt_irq_req && !sys_reset_req && !stop_recovery_req && !irq;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("output active after reset");
    c_irq: cover property (wdt_irq_req);
    c_rst: cover property (sys_reset_req);
    c_rec: cover property (stop_recovery_req);
    c_err: cover property (pready && pslverr);
endmodule // wdt24_chk

bind wdt24_top wdt24_chk wdt24_chk_inst (.sys_clk, .nrst, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .timeout_response_select, .stop_mode, .wdt_irq_req, .sys_reset_req,
    .stop_recovery_req, .irq);

// ### tb/wdt24_core_mdl.sv
// core model: refresh instructions and response counting
`timescale 1ns/1ps
module wdt24_core_mdl (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic keep_alive,
    input wire logic wdt_irq_req,
    input wire logic sys_reset_req,
    output logic     refresh_instr,
    output int       irq_seen,
    output int       rst_seen
);
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            refresh_instr <= 1'b0;
            irq_seen      <= 0;
            rst_seen      <= 0;
        end else begin
            // refresh every other cycle, as a debug session must
            refresh_instr <= keep_alive & ~refresh_instr;
            irq_seen      <= irq_seen + int'(wdt_irq_req);
            rst_seen      <= rst_seen + int'(sys_reset_req);
        end
    end
endmodule // wdt24_core_mdl

// ### tb/testbench.sv
// testbench: scenario tasks for the watchdog top
`timescale 1ns/1ps
module testbench
    import wdt24_pkg::*;
;
    logic        sys_clk, nrst, psel, penable, pwrite, refresh_instr, rerr;
    logic        timeout_response_select, stop_mode, keep_alive, pready, pslverr;
    logic        wdt_irq_req, sys_reset_req, stop_recovery_req, irq;
    logic [31:0] paddr, pwdata, prdata, rdat, a;
    int          errors, cmp_count, irq_seen, rst_seen, c;
    wdt24_top wdt24_top_inst (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .refresh_instr, .timeout_response_select, .stop_mode,
        .wdt_irq_req, .sys_reset_req, .stop_recovery_req, .irq);
    wdt24_core_mdl wdt24_core_mdl_inst (.sys_clk, .nrst, .keep_alive, .wdt_irq_req,
        .sys_reset_req, .refresh_instr, .irq_seen, .rst_seen);
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    task close_out();
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] i, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {18'h0_0000, i, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            close_out();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rst(input logic s);
        @(posedge sys_clk);
        nrst <= 1'b0;
        timeout_response_select <= s;
        stop_mode <= 1'b0;
        keep_alive <= 1'b0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
    endtask
    // reload values stay at 4 or above
    task reld(input logic [7:0] u, input logic [7:0] m, input logic [7:0] l);
        apb(1'b1, WDT24_IDX_UPPER, {24'h00_0000, u});
        apb(1'b1, WDT24_IDX_MIDDLE, {24'h00_0000, m});
        apb(1'b1, WDT24_IDX_LOW, {24'h00_0000, l});
    endtask
    task wait_ev(input int which, input int lim);
        c = 0;
        do begin
            @(posedge sys_clk);
            c++;
        end while (((which == 0) ? wdt_irq_req : sys_reset_req) !== 1'b1 && c < lim);
        if (c >= lim) begin
            errors++;
            close_out();
        end
    endtask
    task t_default();
        rst(1'b1);
        apb(1'b1, WDT24_IDX_CTRL, 32'h0000_0001);
        wait_ev(0, 1100);
        chk(32'(c >= 1026 && c <= 1030), 32'h0000_0001);
    endtask
    task t_irq();
        rst(1'b1);
        reld(8'h00, 8'h00, 8'h10);
        apb(1'b1, WDT24_IDX_CTRL, 32'h0000_0001);
        wait_ev(0, 60);
        chk(32'(stop_recovery_req), 32'h0000_0000);
        chk(32'(c >= 18 && c <= 22), 32'h0000_0001);
        repeat (3) @(posedge sys_clk);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b0, WDT24_IDX_STATUS, 32'h0000_0000);
        chk(rdat, 32'h0000_0003);
        apb(1'b0, WDT24_IDX_UPPER, 32'h0000_0000);
        chk(rdat, 32'h0000_000F);
        apb(1'b1, WDT24_IDX_IRQMSK, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b0, WDT24_IDX_RESET_STATUS_REGISTER, 32'h0000_0000);
        chk(rdat, 32'h0000_0020);
        apb(1'b0, WDT24_IDX_RESET_STATUS_REGISTER, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        apb(1'b1, WDT24_IDX_IRQST, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0000_0000);
    endtask
    task t_refresh();
        rst(1'b1);
        reld(8'h00, 8'h00, 8'h20);
        keep_alive <= 1'b1;
        apb(1'b1, WDT24_IDX_CTRL, 32'h0000_0001);
        repeat (100) @(posedge sys_clk);
        chk(32'(irq_seen), 32'h0000_0000);
        keep_alive <= 1'b0;
        apb(1'b1, WDT24_IDX_CTRL, 32'h0000_0000);
        apb(1'b0, WDT24_IDX_LOW, 32'h0000_0000);
        a = rdat;
        repeat (5) @(posedge sys_clk);
        apb(1'b0, WDT24_IDX_LOW, 32'h0000_0000);
        chk(rdat, a);
        apb(1'b1, WDT24_IDX_LOW, ~a & 32'h0000_00FF);
        apb(1'b0, WDT24_IDX_LOW, 32'h0000_0000);
        chk(rdat, a);
    endtask
    task t_stop();
        rst(1'b1);
        stop_mode <= 1'b1;
        reld(8'h00, 8'h00, 8'h10);
        apb(1'b1, WDT24_IDX_CTRL, 32'h0000_0001);
        wait_ev(0, 60);
        chk(32'(stop_recovery_req), 32'h0000_0001);
        apb(1'b0, WDT24_IDX_RESET_STATUS_REGISTER, 32'h0000_0000);
        chk(rdat, 32'h0000_0030);
        stop_mode <= 1'b0;
    endtask
    task t_rmode();
        rst(1'b0);
        reld(8'h00, 8'h00, 8'h10);
        apb(1'b1, WDT24_IDX_CTRL, 32'h0000_0001);
        wait_ev(1, 60);
        chk(32'(irq_seen), 32'h0000_0000);
        apb(1'b0, 12'hff8, 32'h0000_0000);
        chk(32'(rerr), 32'h0000_0001);
        chk(rdat, 32'h0000_0000);
    endtask
    initial begin
        errors = 0;
        cmp_count = 0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        timeout_response_select = 1'b1;
        stop_mode = 1'b0;
        keep_alive = 1'b0;
        t_default();
        t_irq();
        t_refresh();
        t_stop();
        t_rmode();
        close_out();
    end
endmodule // testbench
